//--- hw/tcc_pkg.sv
// Package: register map, field positions, encodings and reset state of the capture/compare timer
package tcc_pkg;

  // Register byte addresses
  localparam logic [4:0] ADR_CTL    = 5'h00;
  localparam logic [4:0] ADR_IIR    = 5'h01;
  localparam logic [4:0] ADR_IER    = 5'h02;
  localparam logic [4:0] ADR_CNT_L  = 5'h03;
  localparam logic [4:0] ADR_CNT_H  = 5'h04;
  localparam logic [4:0] ADR_CAPCTL = 5'h05;
  localparam logic [4:0] ADR_CAPA_L = 5'h06;
  localparam logic [4:0] ADR_CAPA_H = 5'h07;
  localparam logic [4:0] ADR_CAPB_L = 5'h08;
  localparam logic [4:0] ADR_CAPB_H = 5'h09;
  localparam logic [4:0] ADR_OCCTL1 = 5'h0A;
  localparam logic [4:0] ADR_OCCTL2 = 5'h0B;
  localparam logic [4:0] ADR_CMP_LO = 5'h0C;
  localparam logic [4:0] ADR_CMP_HI = 5'h13;
  localparam logic [4:0] ADR_PWMCTL = 5'h14;

  // Control field positions
  localparam int CTL_EN   = 0;
  localparam int CTL_RLD  = 1;
  localparam int CTL_CONT = 2;
  localparam int CTL_DIV  = 3;
  localparam int CTL_SRC  = 5;
  localparam int CAP_RISE = 0;
  localparam int CAP_FALL = 1;
  localparam int COMPARE_ENABLE    = 0;
  localparam int OC_MAST  = 1;
  localparam int OC_INIT  = 4;
  localparam int PWM_MULT = 0;
  localparam int PWM_PAIR = 1;

  // Flag and enable bit positions
  localparam int F_EOC  = 0;
  localparam int F_CAPA = 1;
  localparam int F_CAPB = 2;
  localparam int F_OC0  = 3;

  // Prescaler masks for divide by 4, 16, 64, 256
  localparam logic [3:0][7:0] PRE_MASK = {8'hFF, 8'h3F, 8'h0F, 8'h03};

  typedef enum logic [1:0] {
    SRC_PRESCALE = 2'b00,
    SRC_RTC      = 2'b01,
    SRC_EV_FALL  = 2'b10,
    SRC_EV_RISE  = 2'b11
  } tcc_clksrc_e;

  typedef enum logic [1:0] {
    ACT_FORCE  = 2'b00,
    ACT_CLEAR  = 2'b01,
    ACT_SET    = 2'b10,
    ACT_TOGGLE = 2'b11
  } tcc_ocact_e;

  typedef struct packed {
    logic [7:0]       ctl;
    logic [6:0]       iir;
    logic [6:0]       ier;
    logic [15:0]      reload;
    logic [15:0]      cnt;
    logic [7:0]       hiLatch;
    logic [7:0]       pre;
    logic [1:0]       capCtl;
    logic [15:0]      capA;
    logic [15:0]      capB;
    logic             lockA;
    logic             lockB;
    logic [7:0]       ocCtl1;
    logic [7:0]       ocCtl2;
    logic [3:0][15:0] cmp;
    logic [3:0]       ocOut;
    logic             ocEnD;
    logic [1:0]       pwmCtl;
    logic [2:0]       evSync;
    logic [2:0]       rtcSync;
    logic [2:0]       cs0Sync;
    logic [2:0]       cs1Sync;
    logic [7:0]       portAOut;
    logic [7:0]       portAOe;
    logic [7:0]       rdata;
  } tcc_state_s;

  localparam tcc_state_s TCC_STATE_RST = '0;

endpackage : tcc_pkg

//--- hw/tcc_timer.sv
// Module: reload timer with event counting, input capture, output compare and port A sharing
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       eventPinA,
  input  wire logic       rtcClk,
  input  wire logic       capturePin0,
  input  wire logic       capturePin1,
  input  wire logic [3:0] pulseOut,
  input  wire logic       timerToggleOut0,
  input  wire logic       timerToggleOut2,
  input  wire logic       portAltMode,
  output logic      [3:0] compareOut,
  output logic      [7:0] portAOut,
  output logic      [7:0] portAOe,
  output logic            timerIrq
);

  tcc_state_s       r;
  tcc_state_s       n;
  logic [6:0]       newFlags;
  logic             srcTick;
  logic             step;
  logic             pwmMode;
  logic             ocEn;
  logic             ocMaster;
  logic             capOk;
  logic             evA;
  logic             evB;
  logic             rdIir;
  logic [15:0]      cntN;
  logic [7:0]       preMask;
  logic [4:0]       cmpOff;
  logic [3:0][15:0] cmpEff;
  logic [3:0][1:0]  actEff;
  logic [3:0]       initEff;
  logic [3:0]       match;
  tcc_clksrc_e      src;

  // Next state of the whole block
  always_comb begin
    n        = r;
    newFlags = '0;
    srcTick  = 1'b0;
    pwmMode  = r.pwmCtl[PWM_MULT];
    ocEn     = r.ocCtl1[COMPARE_ENABLE] & ~pwmMode;
    ocMaster = r.ocCtl1[OC_MAST];
    capOk    = ~pwmMode & (|r.capCtl);
    rdIir    = regRd & (regAddr == ADR_IIR);
    cmpOff   = regAddr - ADR_CMP_LO;
    src      = tcc_clksrc_e'(r.ctl[CTL_SRC +: 2]);
    preMask  = PRE_MASK[r.ctl[CTL_DIV +: 2]];

    // Three-stage synchronisers, edges taken between stages two and three
    n.evSync  = {r.evSync[1:0], eventPinA};
    n.rtcSync = {r.rtcSync[1:0], rtcClk};
    n.cs0Sync = {r.cs0Sync[1:0], capturePin0};
    n.cs1Sync = {r.cs1Sync[1:0], capturePin1};

    // Count source; pin edges reach the counter on the third clock edge
    unique case (src)
      SRC_PRESCALE: srcTick = ((r.pre & preMask) == preMask);
      SRC_RTC:      srcTick = r.rtcSync[1] & ~r.rtcSync[2];
      SRC_EV_FALL:  srcTick = ~r.evSync[1] & r.evSync[2];
      SRC_EV_RISE:  srcTick = r.evSync[1] & ~r.evSync[2];
    endcase
    // Prescaler runs only for the system clock source
    if (r.ctl[CTL_EN] && (src == SRC_PRESCALE)) begin
      n.pre = r.pre + 8'h01;
    end else begin
      n.pre = 8'h00;
    end
    step = r.ctl[CTL_EN] & srcTick;

    // Downcounter; flag only on the step from 1, so a loaded 0 runs a full lap
    cntN = r.cnt;
    if (step) begin
      if (r.cnt == 16'h0001) begin
        newFlags[F_EOC] = 1'b1;
        if (r.ctl[CTL_CONT]) begin
          cntN = r.reload;
        end else begin
          cntN = 16'h0000;
          n.ctl[CTL_EN] = 1'b0;
        end
      end else begin
        cntN = r.cnt - 16'h0001;
      end
    end

    // Register writes; a software write to control wins over the auto-clear
    if (regWr) begin
      case (regAddr)
        ADR_CTL: begin
          n.ctl = regWdata & 8'hFD;
          if (regWdata[CTL_RLD]) begin
            cntN = r.reload;
          end
        end
        ADR_IER:    n.ier = regWdata[6:0];
        ADR_CNT_L:  n.reload[7:0] = regWdata;
        ADR_CNT_H:  n.reload[15:8] = regWdata;
        ADR_CAPCTL: if (!pwmMode) n.capCtl = regWdata[1:0];
        ADR_OCCTL1: if (!pwmMode) n.ocCtl1 = regWdata;
        ADR_OCCTL2: if (!pwmMode) n.ocCtl2 = regWdata;
        ADR_PWMCTL: n.pwmCtl = regWdata[1:0];
        default: begin
          // Capture pairs ignore writes; only compare values are writable here
          if (!pwmMode && (regAddr >= ADR_CMP_LO) && (regAddr <= ADR_CMP_HI)) begin
            if (cmpOff[0]) begin
              n.cmp[cmpOff[2:1]][15:8] = regWdata;
            end else begin
              n.cmp[cmpOff[2:1]][7:0] = regWdata;
            end
          end
        end
      endcase
    end
    n.cnt = cntN;

    // Output compare against the one shared counter
    for (int i = 0; i < 4; i++) begin
      cmpEff[i]  = ocMaster ? r.cmp[0] : r.cmp[i];
      actEff[i]  = ocMaster ? r.ocCtl2[1:0] : r.ocCtl2[2*i +: 2];
      initEff[i] = ocMaster ? r.ocCtl1[OC_INIT] : r.ocCtl1[OC_INIT + i];
      match[i]   = ocEn & step & (cntN == cmpEff[i]);
      if (ocEn && !r.ocEnD) begin
        n.ocOut[i] = initEff[i];
      end else if (ocEn) begin
        unique case (tcc_ocact_e'(actEff[i]))
          ACT_FORCE:  n.ocOut[i] = initEff[i];
          ACT_CLEAR:  if (match[i]) n.ocOut[i] = 1'b0;
          ACT_SET:    if (match[i]) n.ocOut[i] = 1'b1;
          ACT_TOGGLE: if (match[i]) n.ocOut[i] = ~r.ocOut[i];
        endcase
      end
      // A forced output reports no match
      newFlags[F_OC0 + i] = match[i] & (actEff[i] != ACT_FORCE);
    end
    n.ocEnD = ocEn;

    // Input capture; a pin locked by a low-byte read drops its events.
    // The low-byte read cycle blocks too, or the pair could tear across the two reads
    evA = capOk & ~r.lockA & ~(regRd & (regAddr == ADR_CAPA_L))
        & ((r.cs0Sync[1] & ~r.cs0Sync[2] & r.capCtl[CAP_RISE])
        | (~r.cs0Sync[1] & r.cs0Sync[2] & r.capCtl[CAP_FALL]));
    evB = capOk & ~r.lockB & ~(regRd & (regAddr == ADR_CAPB_L))
        & ((r.cs1Sync[1] & ~r.cs1Sync[2] & r.capCtl[CAP_RISE])
        | (~r.cs1Sync[1] & r.cs1Sync[2] & r.capCtl[CAP_FALL]));
    if (evA) begin
      n.capA = r.cnt;
    end
    if (evB) begin
      n.capB = r.cnt;
    end
    newFlags[F_CAPA] = evA;
    newFlags[F_CAPB] = evB;

    // Register reads, data valid only in the following cycle
    n.rdata = 8'h00;
    if (regRd) begin
      case (regAddr)
        ADR_CTL: n.rdata = r.ctl;
        ADR_IIR: n.rdata = {1'b0, r.iir};
        ADR_IER: n.rdata = {1'b0, r.ier};
        ADR_CNT_L: begin
          n.rdata   = r.cnt[7:0];
          n.hiLatch = r.cnt[15:8];
        end
        ADR_CNT_H:  n.rdata = r.hiLatch;
        ADR_CAPCTL: n.rdata = pwmMode ? 8'h00 : {6'h00, r.capCtl};
        ADR_CAPA_L: if (!pwmMode) begin
          n.rdata = r.capA[7:0];
          n.lockA = 1'b1;
        end
        ADR_CAPA_H: if (!pwmMode) begin
          n.rdata = r.capA[15:8];
          n.lockA = 1'b0;
        end
        ADR_CAPB_L: if (!pwmMode) begin
          n.rdata = r.capB[7:0];
          n.lockB = 1'b1;
        end
        ADR_CAPB_H: if (!pwmMode) begin
          n.rdata = r.capB[15:8];
          n.lockB = 1'b0;
        end
        ADR_OCCTL1: n.rdata = pwmMode ? 8'h00 : r.ocCtl1;
        ADR_OCCTL2: n.rdata = pwmMode ? 8'h00 : r.ocCtl2;
        ADR_PWMCTL: n.rdata = {6'h00, r.pwmCtl};
        default: begin
          // Unmapped addresses read as zero
          if (!pwmMode && (regAddr >= ADR_CMP_LO) && (regAddr <= ADR_CMP_HI)) begin
            n.rdata = cmpOff[0] ? r.cmp[cmpOff[2:1]][15:8] : r.cmp[cmpOff[2:1]][7:0];
          end
        end
      endcase
    end

    // Flags: a new event in the read cycle survives the clear
    n.iir = (rdIir ? 7'h00 : r.iir) | newFlags;

    // Port A sharing; PA6 stays an input for the other timer's event pin unless PWM_PAIR is set
    if (portAltMode) begin
      n.portAOut[3:0] = r.pwmCtl[PWM_MULT] ? pulseOut : r.ocOut;
      n.portAOut[5:4] = r.pwmCtl[PWM_PAIR] ? pulseOut[1:0]
                                           : {timerToggleOut2, timerToggleOut0};
      n.portAOut[7:6] = r.pwmCtl[PWM_PAIR] ? pulseOut[3:2] : 2'b00;
      n.portAOe       = r.pwmCtl[PWM_PAIR] ? 8'hFF : 8'h3F;
    end else begin
      n.portAOut = 8'h00;
      n.portAOe  = 8'h00;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= TCC_STATE_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops; request is a gate of flag and enable flops
  assign regRdata   = r.rdata;
  assign compareOut = r.ocOut;
  assign portAOut   = r.portAOut;
  assign portAOe    = r.portAOe;
  assign timerIrq   = |(r.iir & r.ier);

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pwm_blocks: assert property (pwmMode |=> $stable(r.ocOut) && $stable(r.capA))
    else $error("Compare or capture changed in pulse mode");
  a_both_run: assert property (evA && ocEn |=> r.iir[F_CAPA] && r.ocEnD)
    else $error("Capture and compare not concurrent");
  a_iir_clear: assert property (rdIir && (newFlags == 7'h00) |=> r.iir == 7'h00)
    else $error("Flags not cleared by read");
  a_event_latency: assert property ($rose(eventPinA) && (src == SRC_EV_RISE)
      && r.ctl[CTL_EN] && !regWr |-> ##2 step)
    else $error("Event edge not counted on third edge");
  a_prescale_bypass: assert property ((src == SRC_EV_RISE) && !srcTick && !regWr
      |=> $stable(r.cnt))
    else $error("Counter moved without an event edge");
  a_single_pass: assert property (step && (r.cnt == 16'h0001) && !r.ctl[CTL_CONT]
      && !regWr |=> !r.ctl[CTL_EN] && (r.cnt == 16'h0000) && r.iir[F_EOC])
    else $error("End of count mishandled");
  a_cap_latch: assert property (evA |=> r.capA == $past(r.cnt) && r.iir[F_CAPA])
    else $error("Capture A value or flag wrong");
  a_cap_lock: assert property (r.lockA && !(regRd && regAddr == ADR_CAPA_H)
      |=> $stable(r.capA))
    else $error("Locked capture pair overwritten");
  a_cap_ro: assert property (regWr && (regAddr == ADR_CAPB_L) && !evB |=> $stable(r.capB))
    else $error("Capture pair changed by write");
  a_oc_force: assert property (ocEn && r.ocEnD && (actEff[0] == ACT_FORCE)
      |=> r.ocOut[0] == $past(initEff[0]))
    else $error("Forced level not applied");
  a_master_follow: assert property (ocMaster && ocEn && (actEff[0] == ACT_FORCE)
      |=> r.ocOut[1] == $past(r.ocCtl1[OC_INIT]))
    else $error("Output 1 ignores master");
  a_cmp_flag: assert property (match[0] && (actEff[0] == ACT_SET)
      |=> r.ocOut[0] && r.iir[F_OC0])
    else $error("Compare set action or flag missing");
  a_port_mux: assert property (portAltMode && !r.pwmCtl[PWM_MULT]
      |=> portAOut[3:0] == $past(r.ocOut) && portAOe[0])
    else $error("Port A not carrying compare outputs");

  c_capture: cover property (evA ##[1:20] (regRd && regAddr == ADR_CAPA_H));
  c_toggle:  cover property (match[0] && (actEff[0] == ACT_TOGGLE));
  c_clear_race: cover property (rdIir && (newFlags != 7'h00));
  c_master:  cover property (ocMaster && match[0]);

endmodule : tcc_timer
`default_nettype wire

//--- tb/tcc_pins_model.sv
// Far-side model: event, real-time-clock and capture pins of the timer
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
  input  wire logic clk,
  output logic      eventPin,
  output logic      rtcPin,
  output logic      capPin0,
  output logic      capPin1
);
  // Pins are inputs driven from outside, so they idle low from time zero
  initial begin
    eventPin = 1'b0;
    rtcPin   = 1'b0;
    capPin0  = 1'b0;
    capPin1  = 1'b0;
  end

  task automatic setPin(input int unsigned sel, input logic v);
    case (sel)
      0: eventPin <= v;
      1: rtcPin   <= v;
      2: capPin0  <= v;
      default: capPin1 <= v;
    endcase
  endtask : setPin

  // One pulse, four clocks high and four low: far below half the clock rate
  task automatic pulse(input int unsigned sel);
    @(posedge clk);
    setPin(sel, 1'b1);
    repeat (4) @(posedge clk);
    setPin(sel, 1'b0);
    repeat (4) @(posedge clk);
  endtask : pulse
endmodule : tcc_pins_model
`default_nettype wire

//--- tb/tcc_timer_tb.sv
// Testbench: event counting, capture, compare and port A sharing of the timer
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_tb;
  import tcc_pkg::*;
  logic       clk;
  logic       rst_n;
  logic [4:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       evPin;
  logic       rtcPin;
  logic       cap0;
  logic       cap1;
  logic [3:0] pulseOut;
  logic       toggle0;
  logic       toggle2;
  logic       portAltMode;
  logic [3:0] compareOut;
  logic [7:0] portAOut;
  logic [7:0] portAOe;
  logic       timerIrq;
  int         miscompares;
  int         checks_done;

  tcc_timer dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .eventPinA(evPin), .rtcClk(rtcPin),
    .capturePin0(cap0), .capturePin1(cap1), .pulseOut(pulseOut), .timerToggleOut0(toggle0),
    .timerToggleOut2(toggle2), .portAltMode(portAltMode), .compareOut(compareOut),
    .portAOut(portAOut), .portAOe(portAOe), .timerIrq(timerIrq));
  tcc_pins_model pins_u (.clk(clk), .eventPin(evPin), .rtcPin(rtcPin), .capPin0(cap0),
    .capPin1(cap1));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, regRdata});
  endtask : rd

  // Low byte first so the high byte comes from the same count
  task automatic rdCnt(input logic [15:0] exp);
    rd(ADR_CNT_L, exp[7:0]);
    rd(ADR_CNT_H, exp[15:8]);
  endtask : rdCnt

  task automatic test_reset;
    rd(ADR_CTL, 8'h00);
    rd(ADR_IIR, 8'h00);
    rd(ADR_IER, 8'h00);
    chk("compareOut", 16'h0000, {12'h000, compareOut});
  endtask : test_reset

  task automatic test_events;
    wr(ADR_CNT_L, 8'h10);
    wr(ADR_CNT_H, 8'h00);
    wr(ADR_CTL, 8'h63);
    pins_u.pulse(0);
    rdCnt(16'h000F);
    wr(ADR_CTL, 8'h41);
    pins_u.pulse(0);
    rdCnt(16'h000E);
    wr(ADR_CTL, 8'h21);
    pins_u.pulse(1);
    rdCnt(16'h000D);
    wr(ADR_CTL, 8'h61);
  endtask : test_events

  task automatic test_capture;
    wr(ADR_CAPCTL, 8'h01);
    pins_u.pulse(2);
    rd(ADR_IIR, 8'h02);
    rd(ADR_CAPA_L, 8'h0D);
    pins_u.pulse(0);
    pins_u.pulse(2);
    rd(ADR_IIR, 8'h00);
    rd(ADR_CAPA_H, 8'h00);
    rd(ADR_CAPA_L, 8'h0D);
    rd(ADR_CAPA_H, 8'h00);
    wr(ADR_CAPA_L, 8'hFF);
    rd(ADR_CAPA_L, 8'h0D);
    rd(ADR_CAPA_H, 8'h00);
    wr(ADR_IER, 8'h04);
    pins_u.pulse(3);
    chk("timerIrq", 16'h0001, {15'h0, timerIrq});
    rd(ADR_IIR, 8'h04);
    chk("timerIrq", 16'h0000, {15'h0, timerIrq});
    rd(ADR_IIR, 8'h00);
    rd(ADR_CAPB_L, 8'h0C);
    rd(ADR_CAPB_H, 8'h00);
    wr(ADR_IER, 8'h00);
  endtask : test_capture

  task automatic test_compare;
    wr(ADR_CMP_LO, 8'h0A);
    wr(5'h0D, 8'h00);
    wr(5'h0E, 8'h0B);
    wr(5'h0F, 8'h00);
    wr(ADR_OCCTL2, 8'h0E);
    wr(ADR_OCCTL1, 8'h01);
    chk("compareOut", 16'h0000, {12'h000, compareOut});
    pins_u.pulse(0);
    chk("compareOut", 16'h0002, {12'h000, compareOut});
    pins_u.pulse(0);
    chk("compareOut", 16'h0003, {12'h000, compareOut});
    rd(ADR_IIR, 8'h18);
    wr(ADR_OCCTL1, 8'h41);
    repeat (2) @(posedge clk);
    chk("compareOut", 16'h0007, {12'h000, compareOut});
    // Master: outputs 1 to 3 take output 0's value and set action
    wr(ADR_CMP_LO, 8'h09);
    wr(ADR_OCCTL2, 8'h02);
    wr(ADR_OCCTL1, 8'h03);
    pins_u.pulse(0);
    chk("compareOut", 16'h000F, {12'h000, compareOut});
    rd(ADR_IIR, 8'h78);
    // Master with force: all outputs take output 0's initial level
    wr(ADR_OCCTL2, 8'h00);
    repeat (2) @(posedge clk);
    chk("compareOut", 16'h0000, {12'h000, compareOut});
    wr(ADR_OCCTL1, 8'h13);
    repeat (2) @(posedge clk);
    chk("compareOut", 16'h000F, {12'h000, compareOut});
  endtask : test_compare

  // Toggle inputs differ so a swapped PA4/PA5 pair shows up
  task automatic test_port;
    @(posedge clk);
    portAltMode <= 1'b1;
    pulseOut    <= 4'h5;
    toggle0     <= 1'b0;
    toggle2     <= 1'b1;
    repeat (3) @(posedge clk);
    chk("portAOut", 16'h002F, {8'h00, portAOut});
    chk("portAOe", 16'h003F, {8'h00, portAOe});
    wr(ADR_PWMCTL, 8'h03);
    repeat (3) @(posedge clk);
    chk("portAOut", 16'h0055, {8'h00, portAOut});
    chk("portAOe", 16'h00FF, {8'h00, portAOe});
    rd(ADR_CAPCTL, 8'h00);
    wr(ADR_PWMCTL, 8'h00);
    rd(ADR_CAPCTL, 8'h01);
  endtask : test_port

  task automatic test_endcount;
    wr(ADR_CNT_L, 8'h02);
    wr(ADR_CNT_H, 8'h00);
    wr(ADR_CTL, 8'h63);
    pins_u.pulse(0);
    pins_u.pulse(0);
    rd(ADR_IIR, 8'h01);
    rd(ADR_CTL, 8'h60);
  endtask : test_endcount

  // Inputs defined at time zero, reset held for 12 cycles
  initial begin
    miscompares = 0;
    checks_done = 0;
    rst_n = 1'b0;
    regAddr = 5'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    pulseOut = 4'h0;
    toggle0 = 1'b0;
    toggle2 = 1'b0;
    portAltMode = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_events();
    test_capture();
    test_compare();
    test_port();
    test_endcount();
    finish_test();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule : tcc_timer_tb
`default_nettype wire
